// ---- design/clock_divider_pkg.sv ----
// Constants, field layout and state types of the system clock divider.
// How it works
// - At 5 MHz and above, oscillator phases are regenerated to equal length.
// - Prescaler chain gives enables at system clock over 2 up to over 4096.
// - System clock comes from dividing the oscillator by the register ratio.
// - Writing the ratio field changes system clock frequency while running.
// - Register loads FC on reset and hardware standby, holds in software standby.
// - Six upper register bits always read one, writes to them are dropped.
// - Ratio field 00, 01, 10, 11 divides by 2, 4, 8, 16; resets to 00.
// - The divided system clock can be driven out on its output pin.
// - Every on-chip module is paced by the divided system clock enable.
// - Software standby exit wait is counted in divided system clock cycles.
package clock_divider_pkg;

  // Register bus
  localparam int unsigned ADDR_W        = 20;
  localparam logic [19:0] DIV_CTRL_ADDR = 20'hee01b;
  localparam logic [7:0]  DIV_CTRL_RESET = 8'hfc;
  localparam logic [7:0]  READ_IDLE     = 8'h00;

  // Field layout of clock_division_control
  localparam int unsigned RATIO_POS     = 0;
  localparam int unsigned RATIO_W       = 2;
  localparam int unsigned RESERVED_POS  = 2;
  localparam logic [5:0]  RESERVED_ONES = 6'h3f;
  localparam logic [1:0]  RATIO_RESET   = DIV_CTRL_RESET[RATIO_POS +: RATIO_W];

  // Prescaler chain: stage k gives system clock over 2^(k+1)
  localparam int unsigned PRESC_STAGES = 12;

  // Oscillator rate and the threshold for duty regeneration
  localparam int unsigned OSC_FREQ_MHZ     = 40;
  localparam int unsigned DUTY_ADJ_MIN_MHZ = 5;
  localparam bit          DUTY_ADJ_ON      = (OSC_FREQ_MHZ >= DUTY_ADJ_MIN_MHZ);

  // Divider phase counter
  localparam int unsigned PHASE_W = 3;

  // Standby exit wait, in divided system clock ticks
  localparam int unsigned WAKE_W            = 16;
  localparam logic [15:0] WAKE_TICKS_DEFAULT = 16'h0800;

  // Power state of the divider
  typedef enum logic [1:0] {
    ST_RUN,
    ST_STANDBY,
    ST_WAKE
  } power_state_type;

endpackage

// ---- design/prescale_link_if.sv ----
// Interface between the divider and its prescaler chain.
`timescale 1ns/1ps
interface prescale_link_if;
  import clock_divider_pkg::*;

  logic                    sys_tick;   // One pulse per system clock period while running
  logic                    halt;       // Clears and stops the chain
  logic [PRESC_STAGES-1:0] presc_tick; // Per-stage enable pulses

  modport source (
    output sys_tick,
    output halt,
    input  presc_tick
  );

  modport chain (
    input  sys_tick,
    input  halt,
    output presc_tick
  );
endinterface

// ---- design/prescaler_chain.sv ----
// Power-of-two prescaler chain driven by the system clock enable.
`timescale 1ns/1ps
module prescaler_chain
  import clock_divider_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Link to the divider
  prescale_link_if.chain link
);

  typedef struct packed {
    logic [PRESC_STAGES-1:0] count;
    logic [PRESC_STAGES-1:0] tick;
  } chain_state_type;

  chain_state_type state_reg;
  chain_state_type state_next;
  logic [PRESC_STAGES-1:0] stage_due;

  // Stage k fires when the low k+1 count bits are all ones
  genvar k;
  generate
    for (k = 0; k < PRESC_STAGES; k++) begin : g_stage
      assign stage_due[k] = &state_reg.count[k:0];
    end
  endgenerate

  // Count system clock ticks; halting clears the chain like a module reset
  always_comb begin
    state_next      = state_reg;
    state_next.tick = '0;
    if (link.halt) begin
      state_next.count = '0;
    end else if (link.sys_tick) begin
      state_next.count = state_reg.count + 12'h001;
      state_next.tick  = stage_due;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.presc_tick = state_reg.tick;

endmodule

// ---- design/system_clock_divider.sv ----
// System clock divider: ratio register, divided clock, standby handling.
`timescale 1ns/1ps
module system_clock_divider
  import clock_divider_pkg::*;
#(
  parameter logic [15:0] wake_ticks = WAKE_TICKS_DEFAULT
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Register port
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic [7:0]              wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [7:0]              rd_data,
  // Power control
  input  wire logic                    hw_standby_n,
  input  wire logic                    sw_standby,
  output logic                         standby_active,
  // System clock pin
  input  wire logic                    phi_pin_en,
  output logic                         phi_out,
  output logic                         phi_oe,
  // Clock enables for on-chip modules
  output logic                         sys_tick,
  output logic [PRESC_STAGES-1:0]      presc_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0]         hw_sync;
    logic [RATIO_W-1:0] ratio_sel;
    logic [RATIO_W-1:0] ratio_act;
    logic [PHASE_W-1:0] phase_cnt;
    logic               phi;
    logic               phi_oe;
    logic               tick;
    logic               mod_tick;
    power_state_type    state;
    logic [WAKE_W-1:0]  wake_cnt;
    logic [7:0]         rd_data;
    logic               standby;
  } divider_state_type;

  divider_state_type s_reg;
  divider_state_type s_next;

  prescale_link_if link ();

  // Last oscillator cycle of a phase for a given ratio
  function automatic logic [PHASE_W-1:0] phase_end(input logic [RATIO_W-1:0] ratio);
    logic [PHASE_W:0] len;
    len       = 4'h1 << ratio;
    phase_end = PHASE_W'(len - 4'h1);
  endfunction

  logic hw_standby;
  logic phase_last;
  logic period_start;
  logic reg_hit;

  // Second stage of the pin synchroniser is the only one read
  assign hw_standby   = ~s_reg.hw_sync[1];
  assign phase_last   = (s_reg.phase_cnt == phase_end(s_reg.ratio_act));
  assign period_start = phase_last && !s_reg.phi;
  assign reg_hit      = (addr == DIV_CTRL_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next          = s_reg;
    s_next.tick     = 1'b0;
    s_next.mod_tick = 1'b0;
    s_next.rd_data  = READ_IDLE;
    s_next.hw_sync  = {s_reg.hw_sync[0], hw_standby_n};

    // Software writes only the ratio field; upper bits are dropped
    if (wr_en && reg_hit) begin
      s_next.ratio_sel = wr_data[RATIO_POS +: RATIO_W];
    end

    // Reserved bits always return ones
    if (rd_en && reg_hit) begin
      s_next.rd_data = {RESERVED_ONES, s_reg.ratio_sel};
    end

    // Each phase lasts 1, 2, 4 or 8 whole oscillator cycles, so the duty is
    // always exactly half no matter how lopsided the incoming oscillator was
    if (s_reg.state != ST_STANDBY) begin
      if (phase_last) begin
        s_next.phase_cnt = '0;
        s_next.phi       = ~s_reg.phi;
        // New ratio taken only at a period start, never mid-phase
        if (!s_reg.phi) begin
          s_next.tick      = 1'b1;
          s_next.ratio_act = s_reg.ratio_sel;
        end
      end else begin
        s_next.phase_cnt = s_reg.phase_cnt + 3'h1;
      end
    end

    // Power state sequencing
    unique case (s_reg.state)
      ST_RUN: begin
        // Stop at a rising edge so the pin parks high with no runt pulse
        if (period_start && sw_standby) begin
          s_next.state = ST_STANDBY;
          s_next.tick  = 1'b0;
        end
      end
      ST_STANDBY: begin
        if (!sw_standby) begin
          s_next.state    = ST_WAKE;
          s_next.wake_cnt = '0;
        end
      end
      ST_WAKE: begin
        // Wait scales with the ratio because it counts divided ticks
        if (s_next.tick) begin
          if (s_reg.wake_cnt == wake_ticks - 16'h0001) begin
            s_next.state = ST_RUN;
          end else begin
            s_next.wake_cnt = s_reg.wake_cnt + 16'h0001;
          end
        end
      end
    endcase

    // Modules see the divided rate only while running
    s_next.mod_tick = s_next.tick && (s_reg.state == ST_RUN)
                      && (s_next.state == ST_RUN);
    s_next.standby  = (s_next.state != ST_RUN);

    // Pin drive follows the enable; floated in hardware standby
    s_next.phi_oe = phi_pin_en;

    // Hardware standby behaves as a reset of everything but the synchroniser, read data and the standby flag, which it sets
    if (hw_standby) begin
      s_next.ratio_sel = RATIO_RESET;
      s_next.ratio_act = RATIO_RESET;
      s_next.phase_cnt = '0;
      s_next.phi       = 1'b1;
      s_next.phi_oe    = 1'b0;
      s_next.tick      = 1'b0;
      s_next.mod_tick  = 1'b0;
      s_next.state     = ST_RUN;
      s_next.wake_cnt  = '0;
      s_next.standby   = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Software standby leaves ratio_sel untouched; only nrst and hardware
  // standby reload it. The outside holds nrst through clock settling.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_reg           <= '0;
      s_reg.hw_sync   <= 2'h3;
      s_reg.ratio_sel <= RATIO_RESET;
      s_reg.ratio_act <= RATIO_RESET;
      s_reg.phi       <= 1'b1;
      s_reg.state     <= ST_RUN;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler chain

  assign link.sys_tick = s_reg.mod_tick;
  assign link.halt     = s_reg.standby;

  prescaler_chain u_prescaler (
    .clock (clock),
    .nrst  (nrst),
    .link  (link.chain)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data        = s_reg.rd_data;
  assign standby_active = s_reg.standby;
  assign phi_out        = s_reg.phi;
  assign phi_oe         = s_reg.phi_oe;
  assign sys_tick       = s_reg.mod_tick;
  assign presc_tick     = link.presc_tick;

endmodule

// ---- dv/system_clock_divider_monitor.sv ----
// Port checker for the system clock divider.
`timescale 1ns/1ps
module system_clock_divider_monitor
  import clock_divider_pkg::*;
#(
  parameter logic [15:0] wake_ticks = WAKE_TICKS_DEFAULT
) (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    nrst,
  // Register port
  input wire logic [ADDR_W-1:0]       addr,
  input wire logic                    wr_en,
  input wire logic                    rd_en,
  input wire logic [7:0]              rd_data,
  // Power and pin
  input wire logic                    hw_standby_n,
  input wire logic                    standby_active,
  input wire logic                    phi_pin_en,
  input wire logic                    phi_out,
  input wire logic                    phi_oe,
  // Enables
  input wire logic                    sys_tick,
  input wire logic [PRESC_STAGES-1:0] presc_tick
);
  ////////////////////////////////////////
  int unsigned lo_len;

  // Low phase length; standby forces phi high, so those rises are skipped
  always_ff @(posedge clock) begin
    if (!nrst || phi_out) lo_len <= 0;
    else lo_len <= lo_len + 1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////
  reg_read_a: assert property (rd_en && addr == DIV_CTRL_ADDR && hw_standby_n
    |=> rd_data[7:2] == 6'h3f) else $error("reserved bits not read as ones");
  unmapped_read_a: assert property (rd_en && addr != DIV_CTRL_ADDR
    |=> rd_data == 8'h00) else $error("unmapped read not zero");
  read_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data held too long");
  tick_rise_a: assert property (sys_tick |-> $rose(phi_out))
    else $error("tick not at phi rise");
  tick_gap_a: assert property (sys_tick |=> !sys_tick)
    else $error("ticks back to back");
  presc_follow_a: assert property (presc_tick[0] |-> $past(sys_tick))
    else $error("prescaler tick without system tick");
  presc_nest_a: assert property (presc_tick != '0 |-> presc_tick[0])
    else $error("prescaler stages out of step");
  low_phase_a: assert property ($rose(phi_out) && !standby_active
    |-> lo_len inside {1, 2, 4, 8}) else $error("bad low phase length");
  // The clock keeps running through the wake wait, so only entry parks it
  standby_quiet_a: assert property (standby_active |-> !sys_tick)
    else $error("modules ticked in standby");
  standby_park_a: assert property ($rose(standby_active) |-> phi_out)
    else $error("clock not parked high at standby entry");
  pin_off_a: assert property (!phi_pin_en |=> !phi_oe)
    else $error("pin driven while disabled");

  cover property (wr_en && addr == DIV_CTRL_ADDR);
  cover property ($fell(standby_active) ##[1:200] sys_tick);
  cover property (presc_tick[PRESC_STAGES-1]);
endmodule

bind system_clock_divider system_clock_divider_monitor #(.wake_ticks(wake_ticks))
  system_clock_divider_monitor_i (.clock, .nrst, .addr, .wr_en, .rd_en, .rd_data,
  .hw_standby_n, .standby_active, .phi_pin_en, .phi_out, .phi_oe, .sys_tick, .presc_tick);

// ---- dv/system_clock_divider_tb.sv ----
// Self-checking bench for the system clock divider.
`timescale 1ns/1ps
module system_clock_divider_tb;
  import clock_divider_pkg::*;
  localparam logic [15:0] WAKE = 16'h0004;
  logic clock, nrst, wr_en, rd_en, hw_standby_n, sw_standby, phi_pin_en;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wr_data, rd_data, w;
  logic standby_active, phi_out, phi_oe, sys_tick;
  logic [PRESC_STAGES-1:0] presc_tick;
  logic [PRESC_STAGES+1:0] ev;
  logic [7:0] exp_q[$];
  int bad_count, total_checks, ratio_m, n;
  int pk[4] = '{0, 1, 5, 11};

  assign ev = {presc_tick, sys_tick, standby_active};

  system_clock_divider #(.wake_ticks(WAKE)) system_clock_divider_i (.clock, .nrst,
    .addr, .wr_data, .wr_en, .rd_en, .rd_data, .hw_standby_n, .sw_standby,
    .standby_active, .phi_pin_en, .phi_out, .phi_oe, .sys_tick, .presc_tick);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("mismatch at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    if (a == DIV_CTRL_ADDR) ratio_m = d[1:0];
  endtask

  // Model answer: only the ratio field is stored, the rest reads one
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(a == DIV_CTRL_ADDR ? {6'h3f, 2'(ratio_m)} : 8'h00);
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk8(rd_data, exp_q.pop_front());
  endtask

  // Bounded wait so a stuck enable ends in a failed count, not a hang
  task automatic wait_for(input int b, output int c);
    c = 0;
    do begin
      @(posedge clock);
      #1;
      c++;
    end while (ev[b] !== 1'b1 && c < 20000);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    bad_count++;
    report_and_stop();
  end

  ////////////////////////////////////////
  initial begin
    {nrst, wr_en, rd_en, sw_standby, phi_pin_en} = '0;
    {addr, wr_data} = '0;
    hw_standby_n = 1'b1;
    {bad_count, total_checks, ratio_m} = '0;
    w = 8'($urandom(37712));
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    rd(DIV_CTRL_ADDR);
    rd(20'h00000);
    for (int i = 0; i < 8; i++) begin
      w = 8'($urandom);
      wr(i[0] ? DIV_CTRL_ADDR : ADDR_W'($urandom), w);
      rd(DIV_CTRL_ADDR);
    end
    $display("test register done");
    @(posedge clock);
    phi_pin_en <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(DIV_CTRL_ADDR, 8'(r));
      wait_for(1, n);
      wait_for(1, n);
      chkn(n, 2 << r, 2 << r);
    end
    chk8(8'(phi_oe), 8'h01);
    $display("test ratio done");
    wr(DIV_CTRL_ADDR, 8'h00);
    foreach (pk[j]) begin
      wait_for(pk[j] + 2, n);
      wait_for(pk[j] + 2, n);
      chkn(n, 4 << pk[j], 4 << pk[j]);
    end
    $display("test prescaler done");
    wr(DIV_CTRL_ADDR, 8'h01);
    @(posedge clock);
    sw_standby <= 1'b1;
    wait_for(0, n);
    chkn(n, 1, 6);
    chk8(8'(phi_out), 8'h01);
    rd(DIV_CTRL_ADDR);
    @(posedge clock);
    sw_standby <= 1'b0;
    wait_for(1, n);
    chkn(n, 4 * WAKE, 4 * WAKE + 8);
    $display("test standby done");
    @(posedge clock);
    hw_standby_n <= 1'b0;
    repeat (6) @(posedge clock);
    #1 chk8(8'(phi_oe), 8'h00);
    ratio_m = 0;
    @(posedge clock);
    hw_standby_n <= 1'b1;
    repeat (6) @(posedge clock);
    rd(DIV_CTRL_ADDR);
    wr(DIV_CTRL_ADDR, 8'h02);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    ratio_m = 0;
    rd(DIV_CTRL_ADDR);
    $display("test reset done");
    report_and_stop();
  end
endmodule
